// ### core/tcc_pkg.sv
// two-coil chopper control: shared constants, register map, phase codes
// assumes a 125 MHz system clock and a plain address/strobe register port
//
// Function
// - each coil cycles on, fast decay, slow decay every chopper period
// - bridge a starts on rising oscillator edge, bridge b on falling edge
// - fast decay: high sides off, low side opposite polarity on
// - slow decay: both low side switches on regardless of polarity
// - polarity change restarts that bridge's cycle at once, other untouched
// - mixed decay shortens fast decay as the on phase grows longer
// - current setting 1111 is full scale, the highest trip threshold
// - register mixed-decay bit is active high, the pin active low
// - high side threshold comparator above limit reports overcurrent
// - on phase ends as soon as the sense comparator trips
// - comparator already tripped at period start keeps bridge off
// - standalone: mixed decay on while pin low; low polarity is out1->out2
// - current setting zero keeps chopper off, open load flag inactive
package tcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int FD_MAX_NS     = 4000;
  localparam int FD_MIN_NS     = 200;
  // longest time rounds down, least time rounds up
  localparam int FD_MAX_CYC    = FD_MAX_NS / CLK_PERIOD_NS;
  localparam int FD_MIN_CYC    = (FD_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int FD_SHIFT      = 2;
  localparam int ON_W          = 12;
  localparam int FD_W          = 10;
  localparam logic [3:0] OL_PERIODS = 4'he;

  ////////////////////////////////////////////////////////////////////////////
  // chopper phases
  typedef enum logic [3:0] {
    PH_OFF  = 4'b0001,
    PH_ON   = 4'b0010,
    PH_FAST = 4'b0100,
    PH_SLOW = 4'b1000
  } tcc_phase_type;

  // gate bit order: high 1, high 2, low 1, low 2
  localparam int G_HS1 = 0;
  localparam int G_HS2 = 1;
  localparam int G_LS1 = 2;
  localparam int G_LS2 = 3;

  ////////////////////////////////////////////////////////////////////////////
  // pin positions in the synchroniser vector
  localparam int PIN_OSC  = 0;
  localparam int PIN_POLA = 1;
  localparam int PIN_POLB = 2;
  localparam int PIN_MDLA = 3;
  localparam int PIN_MDLB = 4;
  localparam int PIN_SNSA = 5;
  localparam int PIN_SNSB = 6;
  localparam int PIN_OVC  = 7;
  localparam int PIN_SA   = 8;
  localparam int PIN_N    = 9;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h10;

  // control fields
  localparam int CT_CURA = 0;
  localparam int CT_CURB = 4;
  localparam int CT_MDA  = 8;
  localparam int CT_MDB  = 9;
  localparam int CT_POLA = 10;
  localparam int CT_POLB = 11;
  localparam int CT_W    = 12;
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [3:0]  CUR_FULL = 4'hf;
  localparam logic [3:0]  CUR_ZERO = 4'h0;

  // status fields
  localparam int ST_OLA = 0;
  localparam int ST_OLB = 1;
  localparam int ST_ERR = 2;
  localparam int ST_PHA = 3;
  localparam int ST_PHB = 7;
  localparam int ST_SA  = 11;

  // interrupt bits
  localparam int IRQ_OVC = 0;
  localparam int IRQ_OLA = 1;
  localparam int IRQ_OLB = 2;
  localparam int IRQ_W   = 3;

endpackage

// ### core/tcc_sync.sv
// three-stage synchroniser for asynchronous pins
// assumes the caller only compares stage two and three, never stage one
`timescale 1ns/1ps
`default_nettype none
module tcc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  input  wire logic         clk_en_i,
  // pins and stages
  input  wire logic [W-1:0] pin_i,
  output var  logic [W-1:0] q2_o,
  output var  logic [W-1:0] q3_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } tcc_sync_type;

  tcc_sync_type s_reg;
  tcc_sync_type s_next;

  always_comb begin
    s_next    = s_reg;
    s_next.s1 = pin_i;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else if (clk_en_i) begin
      s_reg <= s_next;
    end
  end

  assign q2_o = s_reg.s2;
  assign q3_o = s_reg.s3;

endmodule
`default_nettype wire

// ### core/tcc_bridge.sv
// one full bridge chopper: phase sequencer, gate decode, open load count
// assumes start, polarity, enable and comparator already synchronised
`timescale 1ns/1ps
`default_nettype none
module tcc_bridge
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rstn_i,
  input  wire logic          clk_en_i,
  // control
  input  wire logic          start_i,
  input  wire logic          pol_i,
  input  wire logic          md_en_i,
  input  wire logic          trip_i,
  input  wire logic          zero_i,
  // results
  output var  logic [3:0]    gate_o,
  output var  tcc_phase_type phase_o,
  output var  logic          ol_o,
  output var  logic          ol_evt_o
);

  typedef struct packed {
    tcc_phase_type    state;
    logic             pol;
    logic             reached;
    logic [ON_W-1:0]  on_cnt;
    logic [FD_W-1:0]  fd_cnt;
    logic [3:0]       miss;
    logic             ol;
    logic             ol_evt;
    logic [3:0]       gate;
  } tcc_br_type;

  tcc_br_type s_reg;
  tcc_br_type s_next;

  localparam logic [FD_W-1:0] FD_MAX = FD_W'(FD_MAX_CYC);
  localparam logic [FD_W-1:0] FD_MIN = FD_W'(FD_MIN_CYC);

  // longer on time gives shorter fast decay, floored at the minimum
  function automatic logic [FD_W-1:0] fast_len(input logic md,
                                               input logic [ON_W-1:0] on);
    logic [ON_W-1:0] sub;
    sub = on >> FD_SHIFT;
    if (!md) begin
      fast_len = FD_MIN;
    end else if (sub >= ON_W'(FD_MAX - FD_MIN)) begin
      fast_len = FD_MIN;
    end else begin
      fast_len = FD_MAX - sub[FD_W-1:0];
    end
  endfunction

  function automatic logic [3:0] gates(input tcc_phase_type ph,
                                       input logic pol);
    logic [3:0] g;
    g = 4'h0;
    case (ph)
      PH_ON: begin
        // low polarity drives out1 -> out2
        g[G_HS1] = ~pol;
        g[G_LS2] = ~pol;
        g[G_HS2] = pol;
        g[G_LS1] = pol;
      end
      PH_FAST: begin
        g[G_LS1] = ~pol;
        g[G_LS2] = pol;
      end
      PH_SLOW: begin
        g[G_LS1] = 1'b1;
        g[G_LS2] = 1'b1;
      end
      default: g = 4'h0;
    endcase
    gates = g;
  endfunction

  always_comb begin
    s_next        = s_reg;
    s_next.ol_evt = 1'b0;
    s_next.pol    = pol_i;
    if (zero_i) begin
      s_next.state   = PH_OFF;
      s_next.ol      = 1'b0;
      s_next.miss    = 4'h0;
      s_next.reached = 1'b0;
    end else if (start_i || (pol_i != s_reg.pol) || s_reg.state == PH_OFF)
    begin
      if (start_i && s_reg.state != PH_OFF) begin
        if (s_reg.reached) begin
          s_next.miss = 4'h0;
          s_next.ol   = 1'b0;
        end else if (s_reg.miss != OL_PERIODS) begin
          s_next.miss = s_reg.miss + 4'h1;
        end
        if (s_next.miss == OL_PERIODS) begin
          s_next.ol = 1'b1;
        end
      end
      s_next.reached = 1'b0;
      s_next.on_cnt  = '0;
      // already tripped, stay off this period
      s_next.state   = trip_i ? PH_SLOW : PH_ON;
    end else begin
      case (s_reg.state)
        PH_ON: begin
          if (s_reg.on_cnt != '1) begin
            s_next.on_cnt = s_reg.on_cnt + ON_W'(1);
          end
          if (trip_i) begin
            s_next.reached = 1'b1;
            s_next.fd_cnt  = fast_len(md_en_i, s_reg.on_cnt);
            s_next.state   = PH_FAST;
          end
        end
        PH_FAST: begin
          if (s_reg.fd_cnt <= FD_W'(1)) begin
            s_next.state = PH_SLOW;
          end else begin
            s_next.fd_cnt = s_reg.fd_cnt - FD_W'(1);
          end
        end
        PH_SLOW: s_next.state = PH_SLOW;
        default: s_next.state = PH_OFF;
      endcase
    end
    s_next.ol_evt = s_next.ol & ~s_reg.ol;
    s_next.gate   = gates(s_next.state, pol_i);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg       <= '0;
      s_reg.state <= PH_OFF;
    end else if (clk_en_i) begin
      s_reg <= s_next;
    end
  end

  assign gate_o   = s_reg.gate;
  assign phase_o  = s_reg.state;
  assign ol_o     = s_reg.ol;
  assign ol_evt_o = s_reg.ol_evt;

endmodule
`default_nettype wire

// ### core/tcc_top.sv
// two-coil chopper top: pin filtering, register port, interrupts, bridges
// assumes comparator and oscillator pins are asynchronous to clk_sys_i
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tcc_top (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        clk_en_i,
  // oscillator and mode pins
  input  wire logic        osc_i,
  input  wire logic        standalone_i,
  // standalone bridge pins
  input  wire logic        bridge_a_polarity_i,
  input  wire logic        bridge_b_polarity_i,
  input  wire logic        bridge_a_mixed_decay_low_i,
  input  wire logic        bridge_b_mixed_decay_low_i,
  // comparators
  input  wire logic        bridge_a_sense_input_i,
  input  wire logic        bridge_b_sense_input_i,
  input  wire logic        high_side_threshold_input_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output var  logic [31:0] rdata_o,
  // bridge gates and trip levels
  output var  logic [3:0]  bridge_a_gate_o,
  output var  logic [3:0]  bridge_b_gate_o,
  output var  logic [3:0]  bridge_a_level_o,
  output var  logic [3:0]  bridge_b_level_o,
  // status
  output var  logic        err_o,
  output var  logic        irq_o
);
  import tcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [PIN_N-1:0] flt;
    logic             start_a;
    logic             start_b;
    logic [CT_W-1:0]  ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [31:0]      rdata;
    logic [3:0]       lvl_a;
    logic [3:0]       lvl_b;
    logic             err;
    logic             irq;
  } tcc_top_type;

  tcc_top_type      s_reg;
  tcc_top_type      s_next;

  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] q2;
  logic [PIN_N-1:0] q3;
  logic             pol_a;
  logic             pol_b;
  logic             md_a;
  logic             md_b;
  logic [3:0]       cur_a;
  logic [3:0]       cur_b;
  tcc_phase_type    ph_a;
  tcc_phase_type    ph_b;
  logic             ol_a;
  logic             ol_b;
  logic             ol_evt_a;
  logic             ol_evt_b;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_comb begin
    pins           = '0;
    pins[PIN_OSC]  = osc_i;
    pins[PIN_POLA] = bridge_a_polarity_i;
    pins[PIN_POLB] = bridge_b_polarity_i;
    pins[PIN_MDLA] = bridge_a_mixed_decay_low_i;
    pins[PIN_MDLB] = bridge_b_mixed_decay_low_i;
    pins[PIN_SNSA] = bridge_a_sense_input_i;
    pins[PIN_SNSB] = bridge_b_sense_input_i;
    pins[PIN_OVC]  = high_side_threshold_input_i;
    pins[PIN_SA]   = standalone_i;
  end

  tcc_sync #(
    .W (PIN_N)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .clk_en_i  (clk_en_i),
    .pin_i     (pins),
    .q2_o      (q2),
    .q3_o      (q3)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode select

  always_comb begin
    if (s_reg.flt[PIN_SA]) begin
      pol_a = s_reg.flt[PIN_POLA];
      pol_b = s_reg.flt[PIN_POLB];
      md_a  = ~s_reg.flt[PIN_MDLA];
      md_b  = ~s_reg.flt[PIN_MDLB];
      // forced full scale in standalone mode
      cur_a = CUR_FULL;
      cur_b = CUR_FULL;
    end else begin
      pol_a = s_reg.ctrl[CT_POLA];
      pol_b = s_reg.ctrl[CT_POLB];
      md_a  = s_reg.ctrl[CT_MDA];
      md_b  = s_reg.ctrl[CT_MDB];
      cur_a = s_reg.ctrl[CT_CURA +: 4];
      cur_b = s_reg.ctrl[CT_CURB +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bridges

  tcc_bridge u_bridge_a (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .clk_en_i  (clk_en_i),
    .start_i   (s_reg.start_a),
    .pol_i     (pol_a),
    .md_en_i   (md_a),
    .trip_i    (s_reg.flt[PIN_SNSA]),
    .zero_i    (cur_a == CUR_ZERO),
    .gate_o    (bridge_a_gate_o),
    .phase_o   (ph_a),
    .ol_o      (ol_a),
    .ol_evt_o  (ol_evt_a)
  );

  tcc_bridge u_bridge_b (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .clk_en_i  (clk_en_i),
    .start_i   (s_reg.start_b),
    .pol_i     (pol_b),
    .md_en_i   (md_b),
    .trip_i    (s_reg.flt[PIN_SNSB]),
    .zero_i    (cur_b == CUR_ZERO),
    .gate_o    (bridge_b_gate_o),
    .phase_o   (ph_b),
    .ol_o      (ol_b),
    .ol_evt_o  (ol_evt_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [IRQ_W-1:0] evt;
    logic             ovc_rise;
    s_next   = s_reg;
    evt      = '0;
    ovc_rise = 1'b0;
    // a pin change counts once stages two and three agree
    s_next.flt = (q2 & q3) | (s_reg.flt & (q2 ^ q3));
    // opposite oscillator edges for a and b
    s_next.start_a = s_next.flt[PIN_OSC] & ~s_reg.flt[PIN_OSC];
    s_next.start_b = ~s_next.flt[PIN_OSC] & s_reg.flt[PIN_OSC];
    ovc_rise = s_next.flt[PIN_OVC] & ~s_reg.flt[PIN_OVC];
    evt[IRQ_OVC] = ovc_rise;
    evt[IRQ_OLA] = ol_evt_a;
    evt[IRQ_OLB] = ol_evt_b;

    s_next.rdata = '0;
    if (wr_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          s_next.ctrl = wdata_i[CT_W-1:0];
          // both currents zero clears the error flag
          if (wdata_i[CT_CURA +: 4] == CUR_ZERO &&
              wdata_i[CT_CURB +: 4] == CUR_ZERO) begin
            s_next.err = 1'b0;
          end
        end
        ADDR_IRQ_CLR: s_next.irq_stat = s_reg.irq_stat & ~wdata_i[IRQ_W-1:0];
        ADDR_IRQ_EN:  s_next.irq_en   = wdata_i[IRQ_W-1:0];
        default:      s_next.irq_en   = s_reg.irq_en;
      endcase
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CTRL:     s_next.rdata[CT_W-1:0]  = s_reg.ctrl;
        ADDR_STATUS: begin
          s_next.rdata[ST_OLA]      = ol_a;
          s_next.rdata[ST_OLB]      = ol_b;
          s_next.rdata[ST_ERR]      = s_reg.err;
          s_next.rdata[ST_PHA +: 4] = ph_a;
          s_next.rdata[ST_PHB +: 4] = ph_b;
          s_next.rdata[ST_SA]       = s_reg.flt[PIN_SA];
        end
        ADDR_IRQ_STAT: s_next.rdata[IRQ_W-1:0] = s_reg.irq_stat;
        ADDR_IRQ_EN:   s_next.rdata[IRQ_W-1:0] = s_reg.irq_en;
        default:       s_next.rdata = '0;
      endcase
    end

    // events win over a clear in the same cycle
    s_next.irq_stat = s_next.irq_stat | evt;
    if (ovc_rise) begin
      s_next.err = 1'b1;
    end
    s_next.irq = |(s_next.irq_stat & s_next.irq_en);
    // 1111 is the highest trip level
    s_next.lvl_a = cur_a;
    s_next.lvl_b = cur_b;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg      <= '0;
      s_reg.ctrl <= CTRL_RST;
    end else if (clk_en_i) begin
      s_reg <= s_next;
    end
  end

  assign rdata_o          = s_reg.rdata;
  assign bridge_a_level_o = s_reg.lvl_a;
  assign bridge_b_level_o = s_reg.lvl_b;
  assign err_o            = s_reg.err;
  assign irq_o            = s_reg.irq;

endmodule
`default_nettype wire

// ### test/tcc_top_asserts.sv
// port assertions for the two-coil chopper top
// assumes clk_en_i high; pin ages are counted from the raw pins
`timescale 1ns/1ps
`default_nettype none
module tcc_top_asserts (
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rstn_i,
  // pins
  input wire logic       osc_i,
  input wire logic       standalone_i,
  input wire logic       bridge_a_polarity_i,
  input wire logic       bridge_b_polarity_i,
  input wire logic       high_side_threshold_input_i,
  // outputs
  input wire logic [3:0] bridge_a_gate_o,
  input wire logic [3:0] bridge_b_gate_o,
  input wire logic [3:0] bridge_a_level_o,
  input wire logic       err_o
);
  logic [3:0] rise_age, fall_age, thr_age, pin_age, pins_d;
  wire  [3:0] ga = bridge_a_gate_o;
  wire  [3:0] gb = bridge_b_gate_o;
  wire  [3:0] pins = {osc_i, standalone_i, bridge_a_polarity_i,
                      bridge_b_polarity_i};

  function automatic logic [3:0] age(input logic ev, input logic [3:0] c);
    return ev ? 4'h0 : ((c == 4'hf) ? c : c + 4'h1);
  endfunction

  // pin_age resets to zero: no pin counts as settled early
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pins_d   <= 4'h0;
      rise_age <= 4'hf;
      fall_age <= 4'hf;
      thr_age  <= 4'hf;
      pin_age  <= 4'h0;
    end else begin
      pins_d   <= pins;
      rise_age <= age(osc_i && !pins_d[3], rise_age);
      fall_age <= age(!osc_i && pins_d[3], fall_age);
      thr_age  <= age(high_side_threshold_input_i, thr_age);
      pin_age  <= age(pins[2:0] != pins_d[2:0], pin_age);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_on_a;   ga == 4'b1001; endsequence
  sequence s_on_b;   gb == 4'b0110; endsequence
  sequence s_fast_a; ga[1:0] == 2'b00 && ^ga[3:2]; endsequence
  sequence s_fast_b; gb[1:0] == 2'b00 && ^gb[3:2]; endsequence
  sequence s_sa_ok;  standalone_i && pin_age >= 4'h8 &&
    pins[2:0] == pins_d[2:0]; endsequence

  a_on_shape: assert property (
    ga[1:0] != 2'b00 |-> ga inside {4'b1001, 4'b0110})
    else $error("bridge a on gates malformed");
  a_fast_opp_a: assert property (
    s_on_a ##1 s_fast_a |-> ga == 4'b0100)
    else $error("bridge a fast decay on wrong low side");
  a_fast_opp_b: assert property (
    s_on_b ##1 s_fast_b |-> gb == 4'b1000)
    else $error("bridge b fast decay on wrong low side");
  a_slow_no_high: assert property (
    (ga[3:2] != 2'b11 || ga[1:0] == 2'b00) &&
    (gb[3:2] != 2'b11 || gb[1:0] == 2'b00))
    else $error("high side on with both low sides");
  a_zero_off: assert property (
    (bridge_a_level_o == 4'h0) [*3] |-> ga == 4'h0)
    else $error("bridge a gates on at zero current");
  a_full_scale: assert property (
    s_sa_ok |-> bridge_a_level_o == 4'hf)
    else $error("standalone level not full scale");
  a_pin_pol: assert property (
    s_sa_ok ##0 ga[1:0] != 2'b00
      |-> ga == (bridge_a_polarity_i ? 4'b0110 : 4'b1001))
    else $error("bridge a on gates disagree with pin");
  a_start_rise: assert property (
    s_sa_ok ##0 ($past(ga) == 4'b1100 && ga[1:0] != 2'b00)
      |-> rise_age < 4'hc)
    else $error("bridge a started away from rising edge");
  a_start_fall: assert property (
    s_sa_ok ##0 ($past(gb) == 4'b1100 && gb[1:0] != 2'b00)
      |-> fall_age < 4'hc)
    else $error("bridge b started away from falling edge");
  a_err_cause: assert property (
    $rose(err_o) |-> thr_age < 4'h8)
    else $error("error rose without overcurrent");
endmodule
bind tcc_top tcc_top_asserts u_asserts (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .osc_i(osc_i),
  .standalone_i(standalone_i),
  .bridge_a_polarity_i(bridge_a_polarity_i),
  .bridge_b_polarity_i(bridge_b_polarity_i),
  .high_side_threshold_input_i(high_side_threshold_input_i),
  .bridge_a_gate_o(bridge_a_gate_o), .bridge_b_gate_o(bridge_b_gate_o),
  .bridge_a_level_o(bridge_a_level_o), .err_o(err_o));
`default_nettype wire

// ### test/tcc_coil_model.sv
// coil and sense comparator model for one external bridge
// assumes gate bits [0]hs1 [1]hs2 [2]ls1 [3]ls2, high = on
`timescale 1ns/1ps
`default_nettype none
module tcc_coil_model #(
  parameter int STEP = 40
) (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  // bridge side
  input  wire logic [3:0] gate_i,
  input  wire logic [3:0] level_i,
  input  wire logic       open_i,
  input  wire logic       stuck_i,
  output var  logic       sense_o
);
  int cur;
  // current climbs while a high side conducts; fast decay drains quicker
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur <= 0;
    end else if (open_i) begin
      cur <= 0;
    end else if (gate_i[1:0] != 2'b00) begin
      cur <= cur + 1;
    end else if (gate_i[3:2] == 2'b11) begin
      cur <= (cur > 0) ? cur - 1 : 0;
    end else if (gate_i[3:2] != 2'b00) begin
      cur <= (cur > 2) ? cur - 3 : 0;
    end
  end
  // a broken coil never trips unless level_i is zero; a stuck comparator always reads tripped
  assign sense_o = stuck_i || (cur >= STEP * int'(level_i));
endmodule
`default_nettype wire

// ### test/two_coil_chopper_control_test.sv
// self-checking bench for the two-coil chopper top
// assumes coil models close the sense loop and the bench drives osc
`timescale 1ns/1ps
`default_nettype none
module two_coil_chopper_control_test;
  import tcc_pkg::*;
  logic        clk_sys_i = 1'b0, clk_en = 1'b1;
  logic        rstn_i = 1'b0;
  logic        osc = 1'b0, sa = 1'b0, thr = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        pol_a = 1'b0, pol_b = 1'b1, mdn_a = 1'b1, mdn_b = 1'b1;
  logic        open_a = 1'b0, stuck_a = 1'b0, err, irq, sns_a, sns_b;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0]  g_a, g_b, lv_a, lv_b;
  int          error_cnt = 0, n_checks = 0, cyc = 0, on_len, fd_len, n;

  always #4 clk_sys_i = ~clk_sys_i;
  // period of 1280 cycles, just under the oscillator ceiling
  always begin
    repeat (640) @(posedge clk_sys_i);
    osc <= ~osc;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      $display("unexpected at %0t: run did not finish", $time);
      final_report();
    end
  end

  tcc_top dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .clk_en_i(clk_en),
    .osc_i(osc), .standalone_i(sa),
    .bridge_a_polarity_i(pol_a), .bridge_b_polarity_i(pol_b),
    .bridge_a_mixed_decay_low_i(mdn_a), .bridge_b_mixed_decay_low_i(mdn_b),
    .bridge_a_sense_input_i(sns_a), .bridge_b_sense_input_i(sns_b),
    .high_side_threshold_input_i(thr),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .bridge_a_gate_o(g_a), .bridge_b_gate_o(g_b),
    .bridge_a_level_o(lv_a), .bridge_b_level_o(lv_b),
    .err_o(err), .irq_o(irq));
  tcc_coil_model u_coil_a (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .gate_i(g_a), .level_i(lv_a), .open_i(open_a), .stuck_i(stuck_a),
    .sense_o(sns_a));
  tcc_coil_model u_coil_b (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .gate_i(g_b), .level_i(lv_b), .open_i(1'b0), .stuck_i(1'b0),
    .sense_o(sns_b));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen,
               exp);
    end
  endtask
  task automatic near(input int seen, input int exp);
    chk(32'(seen >= exp - 2 && seen <= exp + 2), 32'h1, "fast length");
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  function automatic int fd_exp(input int on);
    int v;
    v = FD_MAX_CYC - (on >> FD_SHIFT);
    return (v < FD_MIN_CYC) ? FD_MIN_CYC : v;
  endfunction
  // measures one full on and fast decay stretch of bridge a, polarity 0
  task automatic meas_a();
    int t, hi;
    t = 0;
    hi = 0;
    on_len = 0;
    fd_len = 0;
    while (g_a === 4'b1001 && t < 3000) begin
      @(negedge clk_sys_i);
      t++;
    end
    while (g_a !== 4'b1001 && t < 6000) begin
      @(negedge clk_sys_i);
      t++;
    end
    while (g_a === 4'b1001 && on_len < 3000) begin
      @(negedge clk_sys_i);
      on_len++;
      if (sns_a) hi++;
    end
    chk(32'(hi <= 8), 32'h1, "trip to decay delay");
    chk(32'(g_a), 32'h4, "fast decay gates");
    while (g_a === 4'b0100 && fd_len < 3000) begin
      @(negedge clk_sys_i);
      fd_len++;
    end
    chk(32'(g_a), 32'hc, "slow decay gates");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    reg_rd(ADDR_CTRL);
    chk(rv, 32'(CTRL_RST), "ctrl reset");
    clk_en <= 1'b0;
    reg_wr(ADDR_IRQ_EN, 32'h7);
    clk_en <= 1'b1;
    reg_rd(ADDR_IRQ_EN);
    chk(rv, 32'h0, "irq enable reset");
    reg_rd(ADDR_IRQ_STAT);
    chk(rv, 32'h0, "irq status reset");
    reg_wr(ADDR_STATUS, 32'hffff_ffff);
    reg_rd(ADDR_STATUS);
    chk(rv, (32'h1 << ST_PHA) | (32'h1 << ST_PHB), "status");
    reg_rd(8'hfc);
    chk(rv, 32'h0, "unmapped read");
    chk(32'({g_a, g_b, lv_a, lv_b}), 32'h0, "idle outputs");
    $display("reset test done");
  endtask
  task automatic t_decay();
    // mixed decay switched per coil by the host, off then on
    reg_wr(ADDR_CTRL, 32'h8ff);
    cycles(3);
    chk(32'({lv_a, lv_b}), 32'hff, "full scale level");
    meas_a();
    near(fd_len, FD_MIN_CYC);
    reg_wr(ADDR_CTRL, 32'h9ff);
    meas_a();
    n = on_len;
    near(fd_len, fd_exp(on_len));
    reg_wr(ADDR_CTRL, 32'h9f4);
    meas_a();
    chk(32'(on_len < n), 32'h1, "lower level shorter on");
    near(fd_len, fd_exp(on_len));
    $display("decay test done");
  endtask
  task automatic t_stuck();
    @(posedge clk_sys_i);
    stuck_a <= 1'b1;
    cycles(600);
    n = 0;
    repeat (1400) begin
      @(negedge clk_sys_i);
      if (g_a[1:0] != 2'b00) n++;
    end
    chk(32'(n), 32'h0, "on while tripped");
    chk(32'(g_a), 32'hc, "slow while tripped");
    @(posedge clk_sys_i);
    stuck_a <= 1'b0;
    $display("tripped start test done");
  endtask
  task automatic t_open();
    reg_wr(ADDR_CTRL, 32'h8ff);
    reg_wr(ADDR_IRQ_EN, 32'h7);
    @(posedge clk_sys_i);
    open_a <= 1'b1;
    cycles(16 * 1280 + 1300);
    reg_rd(ADDR_STATUS);
    chk(rv & 32'h3, 32'h1 << ST_OLA, "open load flag");
    reg_rd(ADDR_IRQ_STAT);
    chk(rv, 32'h1 << IRQ_OLA, "open load event");
    chk(32'(irq), 32'h1, "irq raised");
    reg_wr(ADDR_IRQ_EN, 32'h0);
    cycles(3);
    chk(32'(irq), 32'h0, "irq masked");
    reg_wr(ADDR_IRQ_CLR, 32'h1 << IRQ_OLA);
    reg_rd(ADDR_IRQ_STAT);
    chk(rv, 32'h0, "irq cleared");
    reg_wr(ADDR_IRQ_EN, 32'h7);
    $display("open load test done");
  endtask
  task automatic t_overcurrent();
    @(posedge clk_sys_i);
    thr <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    thr <= 1'b0;
    open_a <= 1'b0;
    cycles(10);
    chk(32'(err), 32'h1, "overcurrent error");
    reg_rd(ADDR_IRQ_STAT);
    chk(rv & 32'h1, 32'h1 << IRQ_OVC, "overcurrent event");
    chk(32'(irq), 32'h1, "irq on overcurrent");
    reg_wr(ADDR_CTRL, 32'h0);
    cycles(4);
    chk(32'({err, g_a, lv_a}), 32'h0, "zero current idle");
    reg_rd(ADDR_STATUS);
    chk(rv & 32'h7, 32'h0, "flags at zero current");
    reg_wr(ADDR_IRQ_CLR, 32'h7);
    cycles(3);
    chk(32'(irq), 32'h0, "irq after clear");
    $display("overcurrent test done");
  endtask
  task automatic t_standalone();
    logic [3:0] gb;
    @(posedge clk_sys_i);
    sa <= 1'b1;
    // the pin is active low, the register bit active high
    mdn_a <= 1'b0;
    cycles(20);
    chk(32'({lv_a, lv_b}), 32'hff, "standalone level");
    meas_a();
    near(fd_len, fd_exp(on_len));
    @(posedge osc);
    cycles(100);
    gb = g_b;
    @(posedge clk_sys_i);
    pol_a <= 1'b1;
    cycles(10);
    chk(32'(g_a == 4'b0110 || g_a == 4'b1100), 32'h1, "restart");
    chk(32'(g_b), 32'(gb), "bridge b untouched");
    $display("standalone test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_reset();
    t_decay();
    t_stuck();
    t_open();
    t_overcurrent();
    t_standalone();
    final_report();
  end
endmodule
`default_nettype wire
